// *** core/config_word_pkg.sv ***
// Constants for the configuration byte bank and its decoded settings.
// Assumes a byte-wide table access port and a self-timed write strobe from the memory controller.
//
// Overview of operation
// RULE_01: 300001h bit 7 enables two-speed start-up
// RULE_02: Bit 6 enables fail-safe clock monitor
// RULE_03: Bit 4 set multiplies oscillator by four
// RULE_04: Internal-RC PLL only by runtime enable bit
// RULE_05: Codes select external clock power, even adds output
// RULE_06: Crystal, external RC, internal RC codes decoded
// RULE_07: Brown-out power field selects monitor power level
// RULE_08: Brown-out level field selects trip threshold
// RULE_09: Brown-out enable modes; software bit only 01
// RULE_10: Power-up timer enable bit is active low
// RULE_11: Power-up timer independent of brown-out settings
// RULE_12: Watchdog postscale two power code, capped twenty
// RULE_13: Watchdog enable modes; software bit only 10
// RULE_14: 300004h bit 0 selects real-time clock reference
// RULE_15: Reset pin enable bit; else pin is input
// RULE_16: Serial mask bit selects 7 or 5 bits
// RULE_17: Capture routing bit selects port E or H
// RULE_18: Capture unit 2 on port C1 or E7
// RULE_19: Debugger enable active low reserves port B 6,7
// RULE_20: Boot block size 2 kW or 1 kW
// RULE_21: Stack fault reset enable bit
// RULE_22: Unimplemented bits always read as zero
// RULE_23: Unprogrammed reads 1; table access from 300000h
// RULE_24: Byte writes only via self-timed long write
// RULE_25: Decoded outputs captured at reset, held stable; code also recaptures them on each i_load_settings pulse
package config_word_pkg;

    // ------------------------------------------------------------
    // Addresses
    // ------------------------------------------------------------
    localparam logic [21:0] ADDR_OSC_HIGH   = 22'h300001;
    localparam logic [21:0] ADDR_BROWNOUT   = 22'h300002;
    localparam logic [21:0] ADDR_WATCHDOG   = 22'h300003;
    localparam logic [21:0] ADDR_RTC_REF    = 22'h300004;
    localparam logic [21:0] ADDR_PIN_ROUTE  = 22'h300005;
    localparam logic [21:0] ADDR_DEBUG_BOOT = 22'h300006;

    // ------------------------------------------------------------
    // Implemented-bit masks and unprogrammed values
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_OSC_HIGH   = 8'hdf;
    localparam logic [7:0] MASK_BROWNOUT   = 8'h7f;
    localparam logic [7:0] MASK_WATCHDOG   = 8'h7f;
    localparam logic [7:0] MASK_RTC_REF    = 8'h01;
    localparam logic [7:0] MASK_PIN_ROUTE  = 8'h8b;
    localparam logic [7:0] MASK_DEBUG_BOOT = 8'h91;
    localparam logic [7:0] RST_OSC_HIGH    = 8'h08;
    localparam logic [7:0] RST_BROWNOUT    = 8'h7f;
    localparam logic [7:0] RST_WATCHDOG    = 8'h7f;
    localparam logic [7:0] RST_RTC_REF     = 8'h01;
    localparam logic [7:0] RST_PIN_ROUTE   = 8'h8b;
    localparam logic [7:0] RST_DEBUG_BOOT  = 8'h81;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_TWO_SPEED   = 7;
    localparam int POS_CLK_FAIL    = 6;
    localparam int POS_PLL_X4      = 4;
    localparam int POS_OSC_SEL     = 0;
    localparam int POS_BOR_POWER   = 5;
    localparam int POS_BOR_LEVEL   = 3;
    localparam int POS_BOR_ENABLE  = 1;
    localparam int POS_POWERUP_TIMER_EN_N   = 0;
    localparam int POS_WDT_SCALE   = 2;
    localparam int POS_WDT_ENABLE  = 0;
    localparam int POS_RTC_REF     = 0;
    localparam int POS_RESET_PIN   = 7;
    localparam int POS_ADDR_MASK   = 3;
    localparam int POS_CAP_ROUTE   = 1;
    localparam int POS_CAP2_ROUTE  = 0;
    localparam int POS_DEBUG_N     = 7;
    localparam int POS_BOOT_SIZE   = 4;
    localparam int POS_STACK_RESET = 0;
    localparam int POS_RUN_PLL     = 6;

    localparam logic [4:0] WDT_SCALE_MAX = 5'h14;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ      = 125;
    localparam int LONG_WRITE_US  = 2;
    localparam int LONG_WRITE_CYC = LONG_WRITE_US * CLOCK_MHZ;

    // ------------------------------------------------------------
    // Decoded enumerations and write state encoding
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OSC_LOW_POWER_XTAL = 3'h0,
        OSC_XTAL           = 3'h1,
        OSC_CRYSTAL_MED    = 3'h2,
        OSC_CRYSTAL_HIGH   = 3'h3,
        OSC_EXT_CLOCK      = 3'h4,
        OSC_EXT_RC         = 3'h5,
        OSC_INTERNAL_RC    = 3'h6,
        OSC_RESERVED       = 3'h7
    } osc_kind_t;

    typedef enum logic [1:0] {
        BOR_OFF       = 2'h0,
        BOR_SOFTWARE  = 2'h1,
        BOR_HW_NO_SLP = 2'h2,
        BOR_HW_ONLY   = 2'h3
    } bor_mode_t;

    typedef enum logic [1:0] {
        WDT_OFF      = 2'h0,
        WDT_NO_SLEEP = 2'h1,
        WDT_SOFTWARE = 2'h2,
        WDT_ALWAYS   = 2'h3
    } wdt_mode_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b01,
        ST_WRITING = 2'b10
    } write_state_t;

endpackage

// *** core/device_config_word_decode.sv ***
// Configuration byte bank with table access and decoded settings.
// Assumes table read/write strobes are one-cycle pulses synchronous to i_clock.
`timescale 1ns/1ps

module device_config_word_decode (
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    input  wire logic [21:0] i_table_addr,
    input  wire logic [7:0]  i_table_wdata,
    input  wire logic        i_table_write,
    input  wire logic        i_table_read,
    input  wire logic        i_write_start,
    input  wire logic        i_load_settings,
    input  wire logic        i_runtime_pll_enable,
    input  wire logic        i_soft_brownout_enable,
    input  wire logic        i_soft_watchdog_enable,
    input  wire logic        i_sleeping,
    output logic [7:0]       o_table_rdata,
    output logic             o_write_busy,
    output logic             o_two_speed_startup_en,
    output logic             o_clock_fail_monitor_en,
    output logic [2:0]       o_osc_kind,
    output logic [1:0]       o_osc_power,
    output logic             o_clock_output_pin_en,
    output logic             o_pll_active,
    output logic             o_brownout_zero_power,
    output logic [1:0]       o_brownout_power_sel,
    output logic [1:0]       o_brownout_level_sel,
    output logic             o_brownout_active,
    output logic             o_powerup_timer_en,
    output logic [4:0]       o_watchdog_postscale,
    output logic             o_watchdog_active,
    output logic             o_rtc_ref_secondary,
    output logic             o_reset_pin_enable,
    output logic             o_serial_addr_mask_7bit,
    output logic             o_capture_unit_port_e,
    output logic             o_capture2_port_c,
    output logic             o_debugger_enable,
    output logic             o_boot_block_2kw,
    output logic             o_stack_fault_reset_en
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [5:0][7:0]             cells;
        logic [5:0][7:0]             held;
        config_word_pkg::write_state_t wstate;
        logic [8:0]                  wcount;
        logic [2:0]                  wsel;
        logic [7:0]                  wdata;
        logic                        wpend;
        logic [7:0]                  rdata;
        logic                        busy;
        logic                        two_speed;
        logic                        clk_fail;
        logic [2:0]                  osc_kind;
        logic [1:0]                  osc_power;
        logic                        clk_out;
        logic                        pll;
        logic                        bor_zero;
        logic [1:0]                  bor_power;
        logic [1:0]                  bor_level;
        logic                        bor_active;
        logic                        powerup_timer_en;
        logic [4:0]                  wdt_scale;
        logic                        wdt_active;
        logic                        rtc_sec;
        logic                        reset_pin;
        logic                        mask7;
        logic                        cap_e;
        logic                        cap2_c;
        logic                        debug_en;
        logic                        boot2k;
        logic                        stack_rst;
    } state_t;

    state_t st;
    state_t next_st;

    localparam logic [5:0][7:0] MASKS = {config_word_pkg::MASK_DEBUG_BOOT, config_word_pkg::MASK_PIN_ROUTE,
        config_word_pkg::MASK_RTC_REF, config_word_pkg::MASK_WATCHDOG, config_word_pkg::MASK_BROWNOUT,
        config_word_pkg::MASK_OSC_HIGH};
    localparam logic [5:0][7:0] RESETS = {config_word_pkg::RST_DEBUG_BOOT, config_word_pkg::RST_PIN_ROUTE,
        config_word_pkg::RST_RTC_REF, config_word_pkg::RST_WATCHDOG, config_word_pkg::RST_BROWNOUT,
        config_word_pkg::RST_OSC_HIGH};
    localparam logic [8:0] WRITE_CYCLES = 9'(config_word_pkg::LONG_WRITE_CYC);

    // Map a table address to a cell index; 3'h7 means not in this bank
    function automatic logic [2:0] cell_index(input logic [21:0] addr);
        logic [21:0] off;
        off = addr - config_word_pkg::ADDR_OSC_HIGH;
        if (addr >= config_word_pkg::ADDR_OSC_HIGH && addr <= config_word_pkg::ADDR_DEBUG_BOOT) begin
            cell_index = off[2:0];
        end else begin
            cell_index = 3'h7;
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [2:0] ridx;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] c3;
        logic [3:0] fosc;
        logic [1:0] boren;
        logic [1:0] wdten;
        logic [4:0] scale;
        next_st = st;
        ridx = cell_index(i_table_addr);
        // Table read; bytes outside the bank read as zero
        if (i_table_read) begin
            next_st.rdata = (ridx == 3'h7) ? 8'h00 : (st.cells[ridx] & MASKS[ridx]);  // [RULE_22] [RULE_23]
        end
        // Table write only latches address and data
        if (i_table_write && st.wstate == config_word_pkg::ST_IDLE) begin
            next_st.wsel = ridx;
            next_st.wdata = i_table_wdata;
            next_st.wpend = (ridx != 3'h7);
        end
        unique case (st.wstate)
            config_word_pkg::ST_IDLE: begin
                if (i_write_start && st.wpend) begin
                    next_st.wstate = config_word_pkg::ST_WRITING;  // [RULE_24]
                    next_st.wcount = WRITE_CYCLES - 9'h001;
                    next_st.busy = 1'b1;
                end
            end
            config_word_pkg::ST_WRITING: begin
                if (st.wcount == 9'h000) begin
                    // One byte per long write; unimplemented bits are never stored
                    next_st.cells[st.wsel] = st.wdata & MASKS[st.wsel];  // [RULE_24] [RULE_22]
                    next_st.wstate = config_word_pkg::ST_IDLE;
                    next_st.wpend = 1'b0;
                    next_st.busy = 1'b0;
                end else begin
                    next_st.wcount = st.wcount - 9'h001;
                end
            end
        endcase
        // Snapshot only on a load request so running units see constant settings
        if (i_load_settings) begin
            next_st.held = st.cells;  // [RULE_25]
        end
        c1 = st.held[0];
        c2 = st.held[1];
        c3 = st.held[2];
        fosc = c1[config_word_pkg::POS_OSC_SEL +: 4];
        next_st.two_speed = c1[config_word_pkg::POS_TWO_SPEED];  // [RULE_01]
        next_st.clk_fail = c1[config_word_pkg::POS_CLK_FAIL];  // [RULE_02]
        next_st.osc_power = 2'h0;
        next_st.clk_out = 1'b0;
        next_st.osc_kind = config_word_pkg::OSC_RESERVED;
        unique case (fosc)
            4'hd, 4'hc: begin
                next_st.osc_kind = config_word_pkg::OSC_EXT_CLOCK;  // [RULE_05]
                next_st.osc_power = 2'h0;
                next_st.clk_out = ~fosc[0];
            end
            4'hb, 4'ha: begin
                next_st.osc_kind = config_word_pkg::OSC_EXT_CLOCK;  // [RULE_05]
                next_st.osc_power = 2'h1;
                next_st.clk_out = ~fosc[0];
            end
            4'h5, 4'h4: begin
                next_st.osc_kind = config_word_pkg::OSC_EXT_CLOCK;  // [RULE_05]
                next_st.osc_power = 2'h2;
                next_st.clk_out = ~fosc[0];
            end
            4'h3: next_st.osc_kind = config_word_pkg::OSC_CRYSTAL_MED;  // [RULE_06]
            4'h2: next_st.osc_kind = config_word_pkg::OSC_CRYSTAL_HIGH;  // [RULE_06]
            4'h1: next_st.osc_kind = config_word_pkg::OSC_XTAL;  // [RULE_06]
            4'h0: next_st.osc_kind = config_word_pkg::OSC_LOW_POWER_XTAL;  // [RULE_06]
            4'h7, 4'h6: begin
                next_st.osc_kind = config_word_pkg::OSC_EXT_RC;  // [RULE_06]
                next_st.clk_out = ~fosc[0];
            end
            4'h8, 4'h9: begin
                next_st.osc_kind = config_word_pkg::OSC_INTERNAL_RC;  // [RULE_06]
                next_st.clk_out = fosc[0];
            end
            default: next_st.osc_kind = config_word_pkg::OSC_RESERVED;
        endcase
        // Internal RC ignores the configuration PLL bit; runtime bit is live
        if (next_st.osc_kind == config_word_pkg::OSC_INTERNAL_RC) begin
            next_st.pll = i_runtime_pll_enable;  // [RULE_04]
        end else begin
            next_st.pll = i_runtime_pll_enable | c1[config_word_pkg::POS_PLL_X4];  // [RULE_03] [RULE_04]
        end
        next_st.bor_power = c2[config_word_pkg::POS_BOR_POWER +: 2];
        next_st.bor_zero = (next_st.bor_power == 2'h3);  // [RULE_07]
        next_st.bor_level = c2[config_word_pkg::POS_BOR_LEVEL +: 2];  // [RULE_08]
        boren = c2[config_word_pkg::POS_BOR_ENABLE +: 2];
        unique case (config_word_pkg::bor_mode_t'(boren))
            config_word_pkg::BOR_HW_ONLY:   next_st.bor_active = 1'b1;  // [RULE_09]
            config_word_pkg::BOR_HW_NO_SLP: next_st.bor_active = ~i_sleeping;  // [RULE_09]
            config_word_pkg::BOR_SOFTWARE:  next_st.bor_active = i_soft_brownout_enable;  // [RULE_09]
            config_word_pkg::BOR_OFF:       next_st.bor_active = 1'b0;  // [RULE_09]
        endcase
        // Timer enable decoded apart from brown-out fields
        next_st.powerup_timer_en = ~c2[config_word_pkg::POS_POWERUP_TIMER_EN_N];  // [RULE_10] [RULE_11]
        scale = c3[config_word_pkg::POS_WDT_SCALE +: 5];
        next_st.wdt_scale = (scale > config_word_pkg::WDT_SCALE_MAX) ? config_word_pkg::WDT_SCALE_MAX
                                                                     : scale;  // [RULE_12]
        wdten = c3[config_word_pkg::POS_WDT_ENABLE +: 2];
        unique case (config_word_pkg::wdt_mode_t'(wdten))
            config_word_pkg::WDT_ALWAYS:   next_st.wdt_active = 1'b1;  // [RULE_13]
            config_word_pkg::WDT_SOFTWARE: next_st.wdt_active = i_soft_watchdog_enable;  // [RULE_13]
            config_word_pkg::WDT_NO_SLEEP: next_st.wdt_active = ~i_sleeping;  // [RULE_13]
            config_word_pkg::WDT_OFF:      next_st.wdt_active = 1'b0;  // [RULE_13]
        endcase
        next_st.rtc_sec = st.held[3][config_word_pkg::POS_RTC_REF];  // [RULE_14]
        next_st.reset_pin = st.held[4][config_word_pkg::POS_RESET_PIN];  // [RULE_15]
        next_st.mask7 = st.held[4][config_word_pkg::POS_ADDR_MASK];  // [RULE_16]
        next_st.cap_e = st.held[4][config_word_pkg::POS_CAP_ROUTE];  // [RULE_17]
        next_st.cap2_c = st.held[4][config_word_pkg::POS_CAP2_ROUTE];  // [RULE_18]
        next_st.debug_en = ~st.held[5][config_word_pkg::POS_DEBUG_N];  // [RULE_19]
        next_st.boot2k = st.held[5][config_word_pkg::POS_BOOT_SIZE];  // [RULE_20]
        next_st.stack_rst = st.held[5][config_word_pkg::POS_STACK_RESET];  // [RULE_21]
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset restores unprogrammed cell values; real parts keep them in flash
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
            st.cells <= RESETS;  // [RULE_23]
            st.held <= RESETS;  // [RULE_25]
            st.wstate <= config_word_pkg::ST_IDLE;
            st.wsel <= 3'h7;
            st.osc_kind <= config_word_pkg::OSC_INTERNAL_RC;
        end else begin
            st <= next_st;
        end
    end

    assign o_table_rdata = st.rdata;
    assign o_write_busy = st.busy;
    assign o_two_speed_startup_en = st.two_speed;
    assign o_clock_fail_monitor_en = st.clk_fail;
    assign o_osc_kind = st.osc_kind;
    assign o_osc_power = st.osc_power;
    assign o_clock_output_pin_en = st.clk_out;
    assign o_pll_active = st.pll;
    assign o_brownout_zero_power = st.bor_zero;
    assign o_brownout_power_sel = st.bor_power;
    assign o_brownout_level_sel = st.bor_level;
    assign o_brownout_active = st.bor_active;
    assign o_powerup_timer_en = st.powerup_timer_en;
    assign o_watchdog_postscale = st.wdt_scale;
    assign o_watchdog_active = st.wdt_active;
    assign o_rtc_ref_secondary = st.rtc_sec;
    assign o_reset_pin_enable = st.reset_pin;
    assign o_serial_addr_mask_7bit = st.mask7;
    assign o_capture_unit_port_e = st.cap_e;
    assign o_capture2_port_c = st.cap2_c;
    assign o_debugger_enable = st.debug_en;
    assign o_boot_block_2kw = st.boot2k;
    assign o_stack_fault_reset_en = st.stack_rst;

endmodule

// *** tb/cfg_decode_checker.sv ***
// Port-level assertions for the configuration byte bank.
// Assumes it is bound onto device_config_word_decode, ports matched by name.
`timescale 1ns/1ps
module cfg_decode_checker (
    input wire logic        i_clock,
    input wire logic        i_arst_n,
    input wire logic [21:0] i_table_addr,
    input wire logic        i_table_read,
    input wire logic        i_load_settings,
    input wire logic        i_runtime_pll_enable,
    input wire logic [7:0]  o_table_rdata,
    input wire logic        o_write_busy,
    input wire logic [2:0]  o_osc_kind,
    input wire logic        o_pll_active,
    input wire logic        o_brownout_zero_power,
    input wire logic [1:0]  o_brownout_power_sel,
    input wire logic [4:0]  o_watchdog_postscale
);
    // --------------------------------
    // Busy length counter
    // --------------------------------
    logic [8:0] busy_cnt;
    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            busy_cnt <= 9'h0;
        end else begin
            busy_cnt <= o_write_busy ? busy_cnt + 9'h1 : 9'h0;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    property p_rtc_unimpl;
        i_table_read && i_table_addr == config_word_pkg::ADDR_RTC_REF |=> o_table_rdata[7:1] == 7'h0;
    endproperty
    a_rtc_unimpl: assert property (p_rtc_unimpl) else $error("rtc byte upper bits set");
    property p_outside;
        i_table_read && (i_table_addr < 22'h300001 || i_table_addr > 22'h300006) |=> o_table_rdata == 8'h0;
    endproperty
    a_outside: assert property (p_outside) else $error("outside read not zero");
    property p_rd_hold;
        !i_table_read |=> $stable(o_table_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    property p_busy_len;
        $fell(o_write_busy) |-> busy_cnt == 9'(config_word_pkg::LONG_WRITE_CYC);
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("long write length wrong");
    property p_busy_max;
        busy_cnt <= 9'(config_word_pkg::LONG_WRITE_CYC);
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("long write overran");
    property p_zero_pwr;
        o_brownout_zero_power == (o_brownout_power_sel == 2'h3);
    endproperty
    a_zero_pwr: assert property (p_zero_pwr) else $error("zero power monitor mismatch");
    property p_ps_cap;
        o_watchdog_postscale <= 5'h14;
    endproperty
    a_ps_cap: assert property (p_ps_cap) else $error("postscale above cap");
    // Internal RC ignores the configuration PLL bit entirely
    property p_pll_int;
        o_osc_kind == 3'h6 && $past(i_arst_n) |-> o_pll_active == $past(i_runtime_pll_enable);
    endproperty
    a_pll_int: assert property (p_pll_int) else $error("internal RC pll mismatch");
    property p_held;
        !i_load_settings [*2] |=> $stable({o_osc_kind, o_watchdog_postscale, o_brownout_power_sel});
    endproperty
    a_held: assert property (p_held) else $error("settings moved without load");
endmodule

bind device_config_word_decode cfg_decode_checker chk_u (.*);

// *** tb/device_config_word_decode_tb.sv ***
// Self-checking bench for the configuration byte bank.
// Assumes the package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module device_config_word_decode_tb;
    logic i_clock = 1'b0, i_arst_n = 1'b0, i_table_write = 1'b0, i_table_read = 1'b0, i_write_start = 1'b0;
    logic i_load_settings = 1'b0, i_runtime_pll_enable = 1'b0, i_soft_brownout_enable = 1'b0;
    logic i_soft_watchdog_enable = 1'b0, i_sleeping = 1'b0;
    logic [21:0] i_table_addr = 22'h0;
    logic [7:0]  i_table_wdata = 8'h0, o_table_rdata;
    logic [2:0]  o_osc_kind;
    logic [1:0]  o_osc_power, o_brownout_power_sel, o_brownout_level_sel;
    logic [4:0]  o_watchdog_postscale;
    logic o_write_busy, o_two_speed_startup_en, o_clock_fail_monitor_en, o_clock_output_pin_en, o_pll_active;
    logic o_brownout_zero_power, o_brownout_active, o_powerup_timer_en, o_watchdog_active, o_rtc_ref_secondary;
    logic o_reset_pin_enable, o_serial_addr_mask_7bit, o_capture_unit_port_e, o_capture2_port_c;
    logic o_debugger_enable, o_boot_block_2kw, o_stack_fault_reset_en;
    logic [7:0]  masks [8] = '{8'h00, 8'hdf, 8'h7f, 8'h7f, 8'h01, 8'h8b, 8'h91, 8'h00};
    logic [7:0]  rsts [8] = '{8'h00, 8'h08, 8'h7f, 8'h7f, 8'h01, 8'h8b, 8'h81, 8'h00};
    logic [4:0]  ps_tab [5] = '{5'h00, 5'h01, 5'h13, 5'h14, 5'h1f};
    int mismatches = 0;
    int n_checks = 0;

    device_config_word_decode dut_u (.*);
    always #4 i_clock = ~i_clock;

    // --------------------------------
    // Access tasks
    // --------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge i_clock);
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [21:0] a, input logic [7:0] exp);
        i_table_addr = a;
        i_table_read = 1'b1;
        tick;
        i_table_read = 1'b0;
        chk("read data", o_table_rdata, exp);
        tick;
    endtask
    // A spoiled write tries a second table write mid-flight, which must be dropped
    task automatic wr(input logic [21:0] a, input logic [7:0] d, input bit spoil = 0);
        int n;
        i_table_addr = a;
        i_table_wdata = d;
        i_table_write = 1'b1;
        tick;
        i_table_write = 1'b0;
        i_write_start = 1'b1;
        tick;
        i_write_start = 1'b0;
        for (n = 0; n < 300 && o_write_busy === 1'b1; n++) begin
            i_table_write = spoil && n == 5;
            i_table_addr = spoil ? 22'h300004 : a;
            i_table_wdata = 8'h00;
            tick;
        end
        i_table_write = 1'b0;
        chk("long write cycles", n, config_word_pkg::LONG_WRITE_CYC);
        rd(a, d & masks[a[2:0]]);
        if (n == 300) conclude;
    endtask
    task automatic ld;
        i_load_settings = 1'b1;
        tick;
        i_load_settings = 1'b0;
        tick;
    endtask
    task automatic sweep(input logic [1:0] bm, input logic [1:0] wm);
        for (int s = 0; s < 4; s++) begin
            i_soft_brownout_enable = s[0];
            i_soft_watchdog_enable = s[0];
            i_sleeping = s[1];
            tick;
            chk("bor active", o_brownout_active, bm == 3 || (bm == 2 && !s[1]) || (bm == 1 && s[0]));
            chk("wdt active", o_watchdog_active, wm == 3 || (wm == 2 && s[0]) || (wm == 1 && !s[1]));
        end
    endtask
    function automatic logic [4:0] osc_exp(input logic [3:0] c);
        case (c)
            4'hd, 4'hc: return {3'h4, 2'h0};
            4'hb, 4'ha: return {3'h4, 2'h1};
            4'h5, 4'h4: return {3'h4, 2'h2};
            4'h3: return {3'h2, 2'h0};
            4'h2: return {3'h3, 2'h0};
            4'h7, 4'h6: return {3'h5, 2'h0};
            4'h8, 4'h9: return {3'h6, 2'h0};
            4'he, 4'hf: return {3'h7, 2'h0};
            default: return {2'h0, c[0], 2'h0};
        endcase
    endfunction

    // --------------------------------
    // Tests
    // --------------------------------
    initial begin
        repeat (10) @(posedge i_clock);
        #1 i_arst_n = 1'b1;
        for (int k = 0; k < 8; k++) rd(22'h300000 + 22'(k), rsts[k]);
        chk("osc kind", o_osc_kind, 3'h6);
        chk("postscale", o_watchdog_postscale, 5'h14);
        $display("test reset values done");
        wr(22'h300001, 8'h80);
        chk("held two speed", o_two_speed_startup_en, 1'b0);
        for (int c = 0; c < 16; c++) begin
            logic [3:0] cc;
            logic [4:0] e;
            cc = 4'(c);
            e = osc_exp(cc);
            wr(22'h300001, {cc[0], cc[1], 1'b0, cc[2], cc});
            ld;
            chk("two speed", o_two_speed_startup_en, cc[0]);
            chk("fail monitor", o_clock_fail_monitor_en, cc[1]);
            chk("osc kind", o_osc_kind, e[4:2]);
            chk("clock out", o_clock_output_pin_en, cc inside {4'hc, 4'ha, 4'h4, 4'h6, 4'h9});
            chk("pll", o_pll_active, cc[2] && e[4:2] != 3'h6);
            if (e[4:2] == 3'h4) chk("ext power", o_osc_power, e[1:0]);
        end
        wr(22'h300001, 8'h18);
        ld;
        chk("pll", o_pll_active, 1'b0);
        i_runtime_pll_enable = 1'b1;
        tick;
        chk("runtime pll", o_pll_active, 1'b1);
        i_runtime_pll_enable = 1'b0;
        $display("test oscillator done");
        for (int v = 0; v < 4; v++) begin
            logic [1:0] b;
            b = 2'(v);
            wr(22'h300002, {1'b0, b, b, b, b[0]});
            ld;
            chk("bor power", o_brownout_power_sel, b);
            chk("bor level", o_brownout_level_sel, b);
            chk("powerup timer", o_powerup_timer_en, !b[0]);
            chk("bor zero", o_brownout_zero_power, b == 3);
            sweep(b, 2'h3);
        end
        for (int v = 0; v < 5; v++) begin
            wr(22'h300003, {1'b0, ps_tab[v], 2'(v)});
            ld;
            chk("postscale", o_watchdog_postscale, ps_tab[v] > 5'h14 ? 5'h14 : ps_tab[v]);
            sweep(2'h3, 2'(v));
        end
        $display("test brownout and watchdog done");
        for (int v = 0; v < 2; v++) begin
            logic [7:0] d;
            d = v ? 8'hff : 8'h00;
            wr(22'h300004, d);
            wr(22'h300005, d);
            wr(22'h300006, d);
            ld;
            chk("rtc ref", o_rtc_ref_secondary, d[0]);
            chk("reset pin", o_reset_pin_enable, d[7]);
            chk("addr mask", o_serial_addr_mask_7bit, d[3]);
            chk("capture route", o_capture_unit_port_e, d[1]);
            chk("capture2 route", o_capture2_port_c, d[0]);
            chk("debugger", o_debugger_enable, !d[7]);
            chk("boot block", o_boot_block_2kw, d[4]);
            chk("stack reset", o_stack_fault_reset_en, d[0]);
        end
        $display("test routing done");
        wr(22'h300006, 8'h00, 1);
        i_write_start = 1'b1;
        tick;
        i_write_start = 1'b0;
        chk("stale start busy", o_write_busy, 1'b0);
        rd(22'h300004, 8'h01);
        i_arst_n = 1'b0;
        tick;
        i_arst_n = 1'b1;
        rd(22'h300006, 8'h81);
        $display("test refusal and reset done");
        conclude;
    end
endmodule
